// >>> cr_pkg.sv
package cr_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS = 25;
	localparam int US_NS = 1000;
	localparam int US_CYC = (US_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [5:0] US_LAST = 6'(US_CYC - 1);

	// ----------------------------------------
	// Register map and fields
	// ----------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_RX = 8'h04;
	localparam logic [7:0] A_TX = 8'h08;
	localparam logic [7:0] A_STAT = 8'h0c;
	localparam logic [7:0] A_DL = 8'h10;
	localparam logic [7:0] A_SMP = 8'h14;
	localparam int B_ALLREPLY = 0;
	localparam int B_GSYNC = 1;
	localparam int B_EDGE = 2;
	localparam int B_DL_ACT = 3;
	localparam int B_TX_VALID = 8;
	localparam logic [14:0] SAMPLE_CAP = 15'h7530;

	// ----------------------------------------
	// Characters and reply text
	// ----------------------------------------
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_US = 8'h5f;
	localparam logic [15:0] RP_OK = 16'h4f4b;
	localparam logic [15:0] RP_NG = 16'h4e47;
	localparam logic [15:0] RP_EN = 16'h454e;
	localparam logic [15:0] RP_DS = 16'h4453;
	localparam logic [39:0] RP_MODE = 40'h525f534e5f;
	localparam logic [7:0] RP_T = 8'h54;
	localparam logic [7:0] RP_C = 8'h43;
	localparam logic [7:0] RP_N = 8'h4e;
	localparam logic [7:0] RP_ON = 8'h4f;
	localparam logic [7:0] RP_OFF = 8'h46;
	localparam logic [39:0] DEC_BASE = 40'h000000000a;
	localparam logic [39:0] KILO = 40'h00000003e8;
	localparam logic [3:0] TIMER_ITEM = 4'h8;
	localparam logic [3:0] DEC_DIGITS = 4'ha;
	localparam logic [3:0] HEX_CNT_DIGITS = 4'h8;

	// ----------------------------------------
	// Command words, right aligned
	// ----------------------------------------
	localparam logic [71:0] T_BEGIN = 72'h53545254;
	localparam logic [71:0] T_END = 72'h53544f50;
	localparam logic [71:0] T_CNT_AS = 72'h454e4353;
	localparam logic [71:0] T_TIME_AS = 72'h454e5453;
	localparam logic [71:0] T_NO_AS = 72'h44534153;
	localparam logic [71:0] T_MODE_Q = 72'h4d4f443f;
	localparam logic [71:0] T_PCK = 72'h53435052;
	localparam logic [71:0] T_PCF = 72'h5343505246;
	localparam logic [71:0] T_PTM = 72'h53545052;
	localparam logic [71:0] T_PTU = 72'h5354505246;
	localparam logic [71:0] T_GATE_FORCE = 72'h47415445494e5f4453;
	localparam logic [71:0] T_GATE_HONOUR = 72'h47415445494e5f454e;
	localparam logic [71:0] T_GATE_Q = 72'h47415445494e3f;
	localparam logic [71:0] T_RD_ALL = 72'h5244414c3f;
	localparam logic [71:0] T_RD_ALL_H = 72'h5244414c483f;
	localparam logic [71:0] T_CLR_ALL = 72'h434c414c;
	localparam logic [71:0] T_CH_RD = 72'h4354523f;
	localparam logic [71:0] T_CH_RD_H = 72'h435452483f;

	typedef enum logic [1:0] {SM_NONE = 2'b00, SM_CNT = 2'b01, SM_TIME = 2'b10} cr_stop_t;
	typedef enum logic [2:0] {
		RS_IDLE = 3'b000, RS_TXT = 3'b001, RS_NUM = 3'b010,
		RS_SEP = 3'b011, RS_CR = 3'b100, RS_LF = 3'b101
	} cr_rs_t;

	function automatic logic [39:0] pow10(input logic [3:0] k);
		unique case (k)
			4'h0: pow10 = 40'h0000000001;
			4'h1: pow10 = 40'h000000000a;
			4'h2: pow10 = 40'h0000000064;
			4'h3: pow10 = 40'h00000003e8;
			4'h4: pow10 = 40'h0000002710;
			4'h5: pow10 = 40'h00000186a0;
			4'h6: pow10 = 40'h00000f4240;
			4'h7: pow10 = 40'h0000989680;
			4'h8: pow10 = 40'h0005f5e100;
			4'h9: pow10 = 40'h003b9aca00;
			default: pow10 = 40'h0000000001;
		endcase
	endfunction

endpackage

// >>> cr_num_if.sv
interface cr_num_if;
	logic start;
	logic [39:0] value;
	logic hex;
	logic [3:0] ndig;
	logic take;
	logic valid;
	logic [7:0] chr;
	logic last;
	modport ctl (output start, value, hex, ndig, take, input valid, chr, last);
	modport cvt (input start, value, hex, ndig, take, output valid, chr, last);
endinterface

// >>> cr_digit_conv.sv
module cr_digit_conv (
	input logic clock,
	input logic rst,
	cr_num_if.cvt nif
);

	typedef struct packed {
		logic busy;
		logic show;
		logic hex;
		logic [3:0] k;
		logic [3:0] d;
		logic [39:0] rem;
	} cr_cv_t;

	cr_cv_t s, n;

	// ----------------------------------------
	// Decimal digit by repeated subtraction, hex digit by shift
	// ----------------------------------------
	// Slow but tiny: up to ten cycles to settle each decimal digit
	always_comb begin
		n = s;
		nif.valid = s.show;
		nif.last = s.show & (s.k == 4'h0);
		nif.chr = (s.d < 4'ha) ? cr_pkg::CH_0 + 8'(s.d) : cr_pkg::CH_A + 8'(s.d - 4'ha);
		if (!s.busy) begin
			if (nif.start) begin
				n.busy = 1'b1;
				n.show = 1'b0;
				n.hex = nif.hex;
				n.rem = nif.value;
				n.k = nif.ndig - 4'h1;
				n.d = 4'h0;
			end
		end else if (!s.show) begin
			if (s.hex) begin
				n.d = 4'(s.rem >> {s.k, 2'b00});
				n.show = 1'b1;
			end else if (s.rem >= cr_pkg::pow10(s.k) && s.d != 4'h9) begin
				n.rem = s.rem - cr_pkg::pow10(s.k);
				n.d = s.d + 4'h1;
			end else begin
				n.show = 1'b1;
			end
		end else if (nif.take) begin
			n.show = 1'b0;
			n.d = 4'h0;
			if (s.k == 4'h0) begin
				n.busy = 1'b0;
			end else begin
				n.k = s.k - 4'h1;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	a_dec_digit: assert property ( // R18
		@(posedge clock) disable iff (rst)
		nif.valid && !s.hex |-> nif.chr >= cr_pkg::CH_0 && nif.chr <= cr_pkg::CH_9)
		else $error("decimal reply digit out of range");

endmodule

// >>> cr_run_ctl.sv
// What this block does
// R1: Start input rising edge or begin command starts counting.
// R2: Stop input rising edge or stop command ends counting.
// R3: Gate low suspends counting; gate high resumes it.
// R4: Gate-edge mode keeps counting while gate is low.
// R5: Gate-sync mode stores a sample on each gate fall; 30,000 entries.
// R6: Run output high when started and gate high.
// R7: Commands and replies are ASCII lines ending CR then LF.
// R8: All-reply mode answers every command with OK or NG; queries still return their data instead.
// R9: Count autostop stops when preset channel reaches preset; ignored in gate-sync.
// R10: Timer autostop stops at preset time; ignored in gate-sync mode.
// R11: Autostop disable leaves only stop command, stop input, acquisition end.
// R12: Mode query gives fixed letters, stop mode, run state; run off at power-up.
// R13: Preset count set in decimal, kilocounts or counts.
// R14: Preset time set in decimal, milliseconds or microseconds.
// R15: Stop command also ends gate-sync acquisition in progress.
// R16: Gate force-on makes gate true and disables gate-sync acquisition.
// R17: Gate honour restores gate input, is power-up state; query says EN/DS.
// R18: Read-all returns channels 0..7 then timer as 10-digit decimals.
// R19: Clear-all zeroes every channel and the timer.
// R20: Channel read returns one channel or a range; hex variant too.
// R21: Up to 8 connections; only one may own the download.
// R22: During download replies are dropped; only the stop command is taken.
module cr_run_ctl (
	input logic clock,
	input logic rst,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [7:0] paddr,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input logic start_in,
	input logic stop_in,
	input logic gate_in,
	input logic [7:0] cnt_in,
	input logic [1:0] stop_mode_nv,
	output logic run_out,
	output logic sample_we,
	output logic [14:0] sample_addr,
	output logic nv_save,
	output logic [1:0] nv_stop_mode
);

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		logic all_reply;
		logic gsync;
		logic edge_mode;
		logic dl_act;
		logic [2:0] dl_owner;
		logic booted;
		cr_pkg::cr_stop_t stop_mode;
		logic nv_save;
		logic started;
		logic gate_forced;
		logic run;
		logic start_d;
		logic stop_d;
		logic gate_d;
		logic [7:0] cnt_d;
		logic [7:0][31:0] cnt;
		logic [39:0] timer;
		logic [5:0] presc;
		logic [31:0] preset_cnt;
		logic [39:0] preset_time;
		logic sample_we;
		logic [14:0] sample_addr;
		logic [71:0] letters;
		logic [39:0] acc;
		logic [15:0] digs;
		logic [2:0] ndig;
		logic saw_cr;
		cr_pkg::cr_rs_t rs;
		logic [63:0] txt;
		logic [3:0] txt_len;
		logic [3:0] cur;
		logic [3:0] last;
		logic hexr;
		logic conv_on;
		logic tx_valid;
		logic [7:0] tx_char;
	} cr_state_t;

	cr_state_t s, n;
	cr_num_if nif ();

	logic acc_ph, done, wr, rx_wr, exec, gate_eff, cnt_en, tick, clear_now;
	logic acq, is_dig, ok, want, nd0;
	logic [7:0] rx_ch, mch;
	logic [6:0] ch_a, ch_b;
	logic [7:0] hit;

	function automatic logic [6:0] bcd2(input logic [7:0] b);
		bcd2 = 7'({b[7:4], 3'b000}) + 7'({b[7:4], 1'b0}) + 7'(b[3:0]);
	endfunction

	cr_digit_conv u_conv (
		.clock(clock),
		.rst(rst),
		.nif(nif.cvt)
	);

	// ----------------------------------------
	// Per-channel edge detect
	// ----------------------------------------
	for (genvar gi = 0; gi < 8; gi++) begin : g_hit
		assign hit[gi] = cnt_in[gi] & ~s.cnt_d[gi];
	end

	always_comb begin
		n = s;
		acc_ph = psel & penable;
		done = acc_ph & s.pready;
		wr = done & pwrite;
		rx_ch = pwdata[7:0];
		rx_wr = wr & (paddr == cr_pkg::A_RX);
		exec = rx_wr & (rx_ch == cr_pkg::CH_LF) & s.saw_cr; // R7
		gate_eff = gate_in | s.gate_forced; // R16
		cnt_en = s.started & (gate_eff | s.edge_mode); // R3 R4
		tick = s.presc == cr_pkg::US_LAST;
		acq = s.started & s.gsync & ~s.gate_forced;
		clear_now = 1'b0;
		ok = 1'b1;
		want = 1'b0;
		nd0 = s.ndig == 3'h0;
		is_dig = rx_ch >= cr_pkg::CH_0 && rx_ch <= cr_pkg::CH_9;
		ch_a = bcd2(s.ndig == 3'h4 ? s.digs[15:8] : s.digs[7:0]);
		ch_b = bcd2(s.digs[7:0]);
		mch = (s.stop_mode == cr_pkg::SM_TIME) ? cr_pkg::RP_T :
			(s.stop_mode == cr_pkg::SM_CNT) ? cr_pkg::RP_C : cr_pkg::RP_N;
		nif.start = 1'b0;
		nif.take = 1'b0;
		nif.hex = s.hexr;
		nif.value = (s.cur == cr_pkg::TIMER_ITEM) ? s.timer : {8'h00, s.cnt[s.cur[2:0]]};
		nif.ndig = (s.hexr && s.cur != cr_pkg::TIMER_ITEM) ? cr_pkg::HEX_CNT_DIGITS
			: cr_pkg::DEC_DIGITS;
		n.nv_save = 1'b0;
		n.sample_we = 1'b0;

		// ----------------------------------------
		// Bus slave, one wait state
		// ----------------------------------------
		// Any RX write is held off while a reply still streams out
		n.pready = acc_ph & ~s.pready & ~(pwrite & paddr == cr_pkg::A_RX & s.rs != cr_pkg::RS_IDLE);
		n.pslverr = 1'b0;
		if (acc_ph & ~s.pready) begin
			case (paddr)
				cr_pkg::A_CTRL: n.prdata = {29'h0, s.edge_mode, s.gsync, s.all_reply};
				cr_pkg::A_RX: n.prdata = 32'h0;
				cr_pkg::A_TX: n.prdata = {23'h0, s.tx_valid, s.tx_char};
				cr_pkg::A_STAT: n.prdata = {25'h0, s.sample_addr == cr_pkg::SAMPLE_CAP, s.dl_act,
					s.stop_mode, s.gate_forced, s.run, s.started};
				cr_pkg::A_DL: n.prdata = {28'h0, s.dl_act, s.dl_owner};
				cr_pkg::A_SMP: n.prdata = {17'h0, s.sample_addr};
				default: begin
					n.prdata = 32'h0;
					n.pslverr = 1'b1;
				end
			endcase
		end
		// Pop only the character that the read actually returned
		if (done & ~pwrite & paddr == cr_pkg::A_TX & s.prdata[cr_pkg::B_TX_VALID]) begin
			n.tx_valid = 1'b0;
		end
		if (wr & paddr == cr_pkg::A_CTRL) begin
			n.all_reply = pwdata[cr_pkg::B_ALLREPLY];
			n.gsync = pwdata[cr_pkg::B_GSYNC];
			n.edge_mode = pwdata[cr_pkg::B_EDGE];
		end
		if (wr & paddr == cr_pkg::A_DL) begin
			if (pwdata[cr_pkg::B_DL_ACT] & (~s.dl_act | s.dl_owner == pwdata[2:0])) begin // R21
				n.dl_act = 1'b1;
				n.dl_owner = pwdata[2:0];
			end else if (~pwdata[cr_pkg::B_DL_ACT] & s.dl_owner == pwdata[2:0]) begin
				n.dl_act = 1'b0;
			end
		end

		// ----------------------------------------
		// Line assembly
		// ----------------------------------------
		if (rx_wr) begin
			if (rx_ch == cr_pkg::CH_CR) begin
				n.saw_cr = 1'b1;
			end else if (rx_ch == cr_pkg::CH_LF) begin // R7
				n.letters = 72'h0;
				n.acc = 40'h0;
				n.digs = 16'h0;
				n.ndig = 3'h0;
				n.saw_cr = 1'b0;
			end else begin
				n.saw_cr = 1'b0;
				if (is_dig && s.letters != 72'h0) begin
					n.acc = 40'(s.acc * cr_pkg::DEC_BASE) + 40'(rx_ch[3:0]);
					n.digs = {s.digs[11:0], rx_ch[3:0]};
					n.ndig = (s.ndig == 3'h7) ? 3'h7 : s.ndig + 3'h1;
				end else if (nd0) begin
					n.letters = {s.letters[63:0], rx_ch};
				end else begin
					n.ndig = 3'h7;
				end
			end
		end

		// ----------------------------------------
		// Reply streamer
		// ----------------------------------------
		unique case (s.rs)
			cr_pkg::RS_IDLE: begin
			end
			cr_pkg::RS_TXT: if (!s.tx_valid) begin
				n.tx_valid = 1'b1;
				n.tx_char = s.txt[63:56];
				n.txt = {s.txt[55:0], 8'h00};
				n.txt_len = s.txt_len - 4'h1;
				if (s.txt_len == 4'h1) n.rs = cr_pkg::RS_CR;
			end
			cr_pkg::RS_NUM: if (!s.conv_on) begin
				nif.start = 1'b1;
				n.conv_on = 1'b1;
			end else if (nif.valid && !s.tx_valid) begin // R18 R20
				nif.take = 1'b1;
				n.tx_valid = 1'b1;
				n.tx_char = nif.chr;
				if (nif.last) begin
					n.conv_on = 1'b0;
					if (s.cur == s.last) begin
						n.rs = cr_pkg::RS_CR;
					end else begin
						n.cur = s.cur + 4'h1;
						n.rs = cr_pkg::RS_SEP;
					end
				end
			end
			cr_pkg::RS_SEP: if (!s.tx_valid) begin
				n.tx_valid = 1'b1;
				n.tx_char = cr_pkg::CH_SP;
				n.rs = cr_pkg::RS_NUM;
			end
			cr_pkg::RS_CR: if (!s.tx_valid) begin // R7
				n.tx_valid = 1'b1;
				n.tx_char = cr_pkg::CH_CR;
				n.rs = cr_pkg::RS_LF;
			end
			cr_pkg::RS_LF: if (!s.tx_valid) begin
				n.tx_valid = 1'b1;
				n.tx_char = cr_pkg::CH_LF;
				n.rs = cr_pkg::RS_IDLE;
			end
			default: n.rs = cr_pkg::RS_IDLE;
		endcase

		// ----------------------------------------
		// Command execution
		// ----------------------------------------
		// During a download everything but the stop word is dropped unseen
		if (exec & ~(s.dl_act & ~(nd0 && s.letters == cr_pkg::T_END))) begin // R22
			if (nd0 && s.letters == cr_pkg::T_BEGIN) begin
				n.started = 1'b1; // R1
				if (acq | (s.gsync & ~s.gate_forced)) n.sample_addr = 15'h0;
			end else if (nd0 && s.letters == cr_pkg::T_END) begin
				n.started = 1'b0; // R2 R15
				n.dl_act = 1'b0;
			end else if (nd0 && s.letters == cr_pkg::T_CNT_AS) begin
				ok = ~s.gsync; // R9
				if (~s.gsync) n.stop_mode = cr_pkg::SM_CNT;
				n.nv_save = ~s.gsync;
			end else if (nd0 && s.letters == cr_pkg::T_TIME_AS) begin
				ok = ~s.gsync; // R10
				if (~s.gsync) n.stop_mode = cr_pkg::SM_TIME;
				n.nv_save = ~s.gsync;
			end else if (nd0 && s.letters == cr_pkg::T_NO_AS) begin
				n.stop_mode = cr_pkg::SM_NONE; // R11
				n.nv_save = 1'b1;
			end else if (nd0 && s.letters == cr_pkg::T_MODE_Q) begin
				want = 1'b1; // R12
				n.txt = {cr_pkg::RP_MODE, mch, cr_pkg::CH_US, s.started ? cr_pkg::RP_ON : cr_pkg::RP_OFF};
				n.txt_len = 4'h8;
			end else if (!nd0 && s.letters == cr_pkg::T_PCK) begin
				n.preset_cnt = 32'(s.acc * cr_pkg::KILO); // R13
			end else if (!nd0 && s.letters == cr_pkg::T_PCF) begin
				n.preset_cnt = 32'(s.acc); // R13
			end else if (!nd0 && s.letters == cr_pkg::T_PTM) begin
				n.preset_time = 40'(s.acc * cr_pkg::KILO); // R14
			end else if (!nd0 && s.letters == cr_pkg::T_PTU) begin
				n.preset_time = s.acc; // R14
			end else if (nd0 && s.letters == cr_pkg::T_GATE_FORCE) begin
				n.gate_forced = 1'b1; // R16
			end else if (nd0 && s.letters == cr_pkg::T_GATE_HONOUR) begin
				n.gate_forced = 1'b0; // R17
			end else if (nd0 && s.letters == cr_pkg::T_GATE_Q) begin
				want = 1'b1; // R17
				n.txt = {s.gate_forced ? cr_pkg::RP_DS : cr_pkg::RP_EN, 48'h0};
				n.txt_len = 4'h2;
			end else if (nd0 && (s.letters == cr_pkg::T_RD_ALL || s.letters == cr_pkg::T_RD_ALL_H)) begin
				want = 1'b1; // R18
				n.hexr = s.letters == cr_pkg::T_RD_ALL_H;
				n.cur = 4'h0;
				n.last = cr_pkg::TIMER_ITEM;
				n.rs = cr_pkg::RS_NUM;
			end else if (nd0 && s.letters == cr_pkg::T_CLR_ALL) begin
				clear_now = 1'b1; // R19
			end else if ((s.ndig == 3'h2 || s.ndig == 3'h4) &&
				(s.letters == cr_pkg::T_CH_RD || s.letters == cr_pkg::T_CH_RD_H)) begin
				want = 1'b1; // R20
				if (ch_a > 7'h07 || ch_b > 7'h07) begin
					n.txt = {cr_pkg::RP_NG, 48'h0};
					n.txt_len = 4'h2;
				end else begin
					n.hexr = s.letters == cr_pkg::T_CH_RD_H;
					n.cur = ch_a[3:0];
					n.last = (ch_b < ch_a) ? ch_a[3:0] : ch_b[3:0];
					n.rs = cr_pkg::RS_NUM;
				end
			end else begin
				ok = 1'b0;
			end
			if (s.dl_act) begin
				n.rs = cr_pkg::RS_IDLE; // R22
			end else if (want) begin
				if (n.rs == cr_pkg::RS_IDLE) n.rs = cr_pkg::RS_TXT;
			end else if (s.all_reply) begin
				n.txt = {ok ? cr_pkg::RP_OK : cr_pkg::RP_NG, 48'h0}; // R8
				n.txt_len = 4'h2;
				n.rs = cr_pkg::RS_TXT;
			end
		end

		// ----------------------------------------
		// Counting
		// ----------------------------------------
		if (clear_now) begin // R19
			n.timer = 40'h0;
			n.presc = 6'h0;
		end else if (cnt_en) begin // R3 R4
			n.presc = tick ? 6'h0 : s.presc + 6'h1;
			if (tick) n.timer = s.timer + 40'h1;
		end
		for (int i = 0; i < 8; i++) begin
			if (clear_now) begin
				n.cnt[i] = 32'h0;
			end else if (cnt_en & hit[i]) begin
				n.cnt[i] = s.cnt[i] + 32'h1;
			end
		end
		n.cnt_d = cnt_in;
		n.start_d = start_in;
		n.stop_d = stop_in;
		n.gate_d = gate_in;

		// ----------------------------------------
		// Run control
		// ----------------------------------------
		if (start_in & ~s.start_d) n.started = 1'b1; // R1
		if (stop_in & ~s.stop_d) n.started = 1'b0; // R2
		if (s.started & s.stop_mode == cr_pkg::SM_CNT & s.cnt[7] >= s.preset_cnt) begin
			n.started = 1'b0; // R9
		end
		if (s.started & s.stop_mode == cr_pkg::SM_TIME & s.timer >= s.preset_time) begin
			n.started = 1'b0; // R10
		end
		// Sample storage sits outside; this side only steps its address
		if (acq & s.gate_d & ~gate_in & s.sample_addr != cr_pkg::SAMPLE_CAP) begin // R5
			n.sample_we = 1'b1;
			n.sample_addr = s.sample_addr + 15'h1;
		end
		if (acq & s.sample_addr == cr_pkg::SAMPLE_CAP) n.started = 1'b0; // R11
		n.run = s.started & gate_eff; // R6
		// Stop mode survives power cycles through the outside store
		if (!s.booted) begin // R12
			n.booted = 1'b1;
			n.stop_mode = (stop_mode_nv == 2'b11) ? cr_pkg::SM_NONE : cr_pkg::cr_stop_t'(stop_mode_nv);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign run_out = s.run;
	assign sample_we = s.sample_we;
	assign sample_addr = s.sample_addr;
	assign nv_save = s.nv_save;
	assign nv_stop_mode = s.stop_mode;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_begin_edge: assert property ( // R1
		@(posedge clock) disable iff (rst)
		$rose(start_in) && !stop_in && s.booted && !(s.started && s.stop_mode != cr_pkg::SM_NONE)
		&& !(s.started && s.gsync) |=> s.started)
		else $error("start edge did not start counting");

	a_end_edge: assert property ( // R2
		@(posedge clock) disable iff (rst)
		$rose(stop_in) |=> !s.started)
		else $error("stop edge did not stop counting");

	a_gate_hold: assert property ( // R3
		@(posedge clock) disable iff (rst)
		s.started && !gate_in && !s.gate_forced && !s.edge_mode && !clear_now |=> $stable(s.timer))
		else $error("timer moved while gate low");

	a_edge_counts: assert property ( // R4
		@(posedge clock) disable iff (rst)
		s.started && s.edge_mode && !gate_in && tick && !clear_now
		|=> s.timer == $past(s.timer) + 40'h1)
		else $error("edge mode did not count with gate low");

	a_sample_fall: assert property ( // R5
		@(posedge clock) disable iff (rst)
		acq && s.gate_d && !gate_in && s.sample_addr != cr_pkg::SAMPLE_CAP
		|=> sample_we && sample_addr == $past(s.sample_addr) + 15'h1)
		else $error("gate fall stored no sample");

	a_run_level: assert property ( // R6
		@(posedge clock) disable iff (rst)
		s.started && gate_in ##1 s.started |-> run_out)
		else $error("run output low while counting");

	a_line_end: assert property ( // R7
		@(posedge clock) disable iff (rst)
		s.rs == cr_pkg::RS_LF && $past(s.rs) != cr_pkg::RS_LF |-> $past(s.rs) == cr_pkg::RS_CR)
		else $error("line feed not preceded by carriage return");

	a_preset_stop: assert property ( // R9
		@(posedge clock) disable iff (rst)
		s.started && s.stop_mode == cr_pkg::SM_CNT && s.cnt[7] >= s.preset_cnt |=> !s.started)
		else $error("count autostop missed");

	a_timer_stop: assert property ( // R10
		@(posedge clock) disable iff (rst)
		s.started && s.stop_mode == cr_pkg::SM_TIME && s.timer >= s.preset_time |=> !s.started)
		else $error("timer autostop missed");

endmodule

// >>> cr_host_model.sv
module cr_host_model (
	input logic clock,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	output logic hang
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		hang = 1'b0;
	end

	// ----------------------------------------
	// Bus cycle
	// ----------------------------------------
	// Held until pready is sampled high; RX writes may stall while a reply streams
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 400);
		r = prdata;
		e = pslverr;
		if (n >= 400) hang <= 1'b1;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// ----------------------------------------
	// Command lines
	// ----------------------------------------
	task automatic send(input string c);
		logic [31:0] r;
		logic e;
		c = {c, "\r\n"};
		for (int i = 0; i < c.len(); i++) apb(1'b1, cr_pkg::A_RX, {24'h0, c[i]}, r, e);
	endtask

	// Polls TX until LF; a reply that never ends flags a hang
	task automatic get_line(output string s);
		logic [31:0] r;
		logic e;
		int n;
		s = "";
		for (n = 0; n < 300; n++) begin
			apb(1'b0, cr_pkg::A_TX, 32'h0, r, e);
			if (r[cr_pkg::B_TX_VALID] === 1'b1) begin
				s = $sformatf("%s%c", s, r[7:0]);
				if (r[7:0] === cr_pkg::CH_LF) break;
			end
		end
		if (n >= 300) hang <= 1'b1;
	endtask

	task automatic ask(input string c, output string s);
		send(c);
		get_line(s);
	endtask
endmodule

// >>> counter_timer_run_control_tb.sv
module counter_timer_run_control_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic clock, rst, psel, penable, pwrite, pready, pslverr, hang;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic start_in, stop_in, gate_in, run_out, sample_we, nv_save;
	logic [7:0] cnt_in;
	logic [1:0] stop_mode_nv, nv_stop_mode;
	logic [14:0] sample_addr;
	int error_cnt = 0;
	int compares = 0;
	string s, z;

	cr_run_ctl uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .start_in(start_in), .stop_in(stop_in),
		.gate_in(gate_in), .cnt_in(cnt_in), .stop_mode_nv(stop_mode_nv),
		.run_out(run_out), .sample_we(sample_we), .sample_addr(sample_addr),
		.nv_save(nv_save), .nv_stop_mode(nv_stop_mode));
	cr_host_model host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hang(hang));

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_str(input string got, input string exp);
		compares++;
		if (got != exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("errors=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Command word from its right-aligned package constant
	function automatic string w2s(input logic [71:0] w);
		string t;
		t = "";
		for (int i = 8; i >= 0; i--) begin
			if (w[i*8 +: 8] != 8'h00) t = $sformatf("%s%c", t, w[i*8 +: 8]);
		end
		return t;
	endfunction

	task automatic pulse(input logic stop);
		if (stop) stop_in <= 1'b1;
		else start_in <= 1'b1;
		repeat (4) @(posedge clock);
		stop_in <= 1'b0;
		start_in <= 1'b0;
		repeat (3) @(posedge clock);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_pins();
		host.ask(w2s(cr_pkg::T_MODE_Q), s);
		chk_str(s, "R_SN_T_F\r\n");
		host.send(w2s(cr_pkg::T_NO_AS));
		pulse(1'b0);
		chk_bit(run_out, 1'b1);
		gate_in <= 1'b0;
		repeat (3) @(posedge clock);
		chk_bit(run_out, 1'b0);
		gate_in <= 1'b1;
		repeat (3) @(posedge clock);
		chk_bit(run_out, 1'b1);
		pulse(1'b1);
		chk_bit(run_out, 1'b0);
	endtask

	task automatic t_gate();
		gate_in <= 1'b0;
		host.send(w2s(cr_pkg::T_GATE_FORCE));
		host.ask(w2s(cr_pkg::T_GATE_Q), s);
		chk_str(s, "DS\r\n");
		host.send(w2s(cr_pkg::T_BEGIN));
		repeat (3) @(posedge clock);
		chk_bit(run_out, 1'b1);
		host.send("STOP");
		repeat (3) @(posedge clock);
		chk_bit(run_out, 1'b0);
		host.send(w2s(cr_pkg::T_GATE_HONOUR));
		host.ask(w2s(cr_pkg::T_GATE_Q), s);
		chk_str(s, "EN\r\n");
		gate_in <= 1'b1;
	endtask

	// Auto-stop must land on exactly the third count, not earlier
	task automatic t_auto();
		host.send({w2s(cr_pkg::T_PCF), "3"});
		host.send(w2s(cr_pkg::T_CNT_AS));
		@(posedge clock);
		chk_bit(nv_save, 1'b1);
		chk_bit(nv_stop_mode === cr_pkg::SM_CNT, 1'b1);
		host.ask(w2s(cr_pkg::T_MODE_Q), s);
		chk_str(s, "R_SN_C_F\r\n");
		host.send(w2s(cr_pkg::T_BEGIN));
		repeat (2) @(posedge clock);
		for (int i = 0; i < 3; i++) begin
			chk_bit(run_out, 1'b1);
			cnt_in[7] <= 1'b1;
			@(posedge clock);
			cnt_in[7] <= 1'b0;
			repeat (3) @(posedge clock);
		end
		chk_bit(run_out, 1'b0);
		host.ask({w2s(cr_pkg::T_CH_RD), "07"}, s);
		chk_str(s, "0000000003\r\n");
	endtask

	task automatic t_clear();
		host.send(w2s(cr_pkg::T_CLR_ALL));
		host.ask(w2s(cr_pkg::T_RD_ALL), s);
		z = "0000000000";
		for (int i = 0; i < 8; i++) z = {z, " 0000000000"};
		chk_str(s, {z, "\r\n"});
	endtask

	task automatic t_reply();
		logic [31:0] r;
		logic e;
		host.apb(1'b1, cr_pkg::A_CTRL, 32'h1, r, e);
		host.ask("STOP", s);
		chk_str(s, "OK\r\n");
		host.ask("FOO", s);
		chk_str(s, "NG\r\n");
		host.apb(1'b1, cr_pkg::A_CTRL, 32'h0, r, e);
		host.apb(1'b0, 8'h18, 32'h0, r, e);
		chk_bit(e, 1'b1);
		chk_bit(r === 32'h0, 1'b1);
	endtask

	// Gate-sync plus gate-edge: a sample per gate fall, counts go on while gate is low
	task automatic t_sync();
		logic [31:0] r;
		logic e;
		host.apb(1'b1, cr_pkg::A_CTRL, 32'h6, r, e);
		host.send(w2s(cr_pkg::T_BEGIN));
		gate_in <= 1'b0;
		repeat (2) @(posedge clock);
		chk_bit(sample_we, 1'b1);
		chk_bit(sample_addr === 15'h1, 1'b1);
		cnt_in[0] <= 1'b1;
		@(posedge clock);
		cnt_in[0] <= 1'b0;
		repeat (45) @(posedge clock);
		chk_bit(run_out, 1'b0);
		host.send("STOP");
		gate_in <= 1'b1;
		repeat (3) @(posedge clock);
		chk_bit(run_out, 1'b0);
		host.ask({w2s(cr_pkg::T_CH_RD), "00"}, s);
		chk_str(s, "0000000001\r\n");
	endtask

	// ----------------------------------------
	// Clock, reset, sequence
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	always @(posedge clock) if (hang === 1'b1) begin
		error_cnt++;
		report_and_stop();
	end

	initial begin
		repeat (100000) @(posedge clock);
		error_cnt++;
		report_and_stop();
	end

	initial begin
		rst = 1'b1;
		start_in = 1'b0;
		stop_in = 1'b0;
		gate_in = 1'b1;
		cnt_in = 8'h00;
		stop_mode_nv = 2'b10;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		chk_bit(run_out, 1'b0);
		t_pins();
		t_gate();
		t_auto();
		t_clear();
		t_reply();
		t_sync();
		report_and_stop();
	end
endmodule
